/* shared/ccw_cfg.svh */
// ccw_cfg.svh: constants for the capability word block.
// assumes inclusion by bare name from package and design files.
`ifndef CCW_CFG_SVH
`define CCW_CFG_SVH

// ****************************************
// selection on the coprocessor move path
// ****************************************
`define CCW_REG_NUM          5'h10
`define CCW_REG_SEL          3'h3

// ****************************************
// field positions
// ****************************************
`define CCW_NEXT_BIT         31
`define CCW_UNIMP_HI         30
`define CCW_UNIMP_LO         23
`define CCW_PFW_HI           22
`define CCW_PFW_LO           21
`define CCW_CIR_HI           20
`define CCW_CIR_LO           18
`define CCW_MCU_BIT          17
`define CCW_EES_BIT          16
`define CCW_ISS_HI           15
`define CCW_ISS_LO           14
`define CCW_TLR_BIT          13
`define CCW_INH_BIT          12
`define CCW_SX2_BIT          11
`define CCW_SX_BIT           10
`define CCW_EVC_BIT          6
`define CCW_VIS_BIT          5
`define CCW_BOOT_BIT         6

// ****************************************
// priority level placement
// ****************************************
`define CCW_STAT_MSB_BIT     18
`define CCW_STAT_MSB2_BIT    16
`define CCW_CAUSE_MSB_BIT    17
`define CCW_CAUSE_MSB2_BIT   16
`define CCW_PRIO_LOW_HI      15
`define CCW_PRIO_LOW_LO      10

// ****************************************
// field values and timing
// ****************************************
`define CCW_PFW_8BIT         2'h1
`define CCW_PFW_6BIT         2'h0
`define CCW_CIR_REV1         3'h0
`define CCW_ISS_BOTH_CMP     2'h3
`define CCW_ISS_BOTH_BASE    2'h2
`define CCW_ISS_CMP_ONLY     2'h1
`define CCW_ISS_BASE_ONLY    2'h0
`define CCW_SETTLE_CYC       2'h2

`endif

/* shared/ccw_pkg.sv */
// ccw_pkg.sv: types shared by the capability word design files.
// assumes ccw_cfg.svh is on the include path.
`default_nettype none

package ccw_pkg;
	`include "ccw_cfg.svh"

	// strap capture sequence after reset release
	typedef enum logic [2:0] {
		CCW_ST_SETTLE  = 3'b001,
		CCW_ST_CAPTURE = 3'b010,
		CCW_ST_RUN     = 3'b100
	} ccw_state_t;

	typedef logic [1:0] ccw_iss_t;
	typedef logic [7:0] ccw_prio_t;
endpackage

`default_nettype wire

/* hw/ccw_sync.sv */
// ccw_sync.sv: two-flop synchroniser for pin levels.
// assumes the input is a slowly changing level, such as a strap.
`default_nettype none

module ccw_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_sys,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] stab_q;

	// first stage feeds only the second
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			meta_q <= '0;
			stab_q <= '0;
		end else begin
			meta_q <= async_in;
			stab_q <= meta_q;
		end
	end

	assign sync_out = stab_q;
endmodule

`default_nettype wire

/* hw/ccw_prio_map.sv */
// ccw_prio_map.sv: extracts priority levels from status and cause words.
// assumes words come from core logic on the same clock; output is combinational.
`default_nettype none

`include "ccw_cfg.svh"

module ccw_prio_map
	import ccw_pkg::*;
(
	input  wire logic      [31:0] status_word,
	input  wire logic      [31:0] cause_word,
	input  wire logic      [1:0]  width_code,
	output ccw_prio_t             current_level,
	output ccw_prio_t             requested_level
);
	logic wide;

	assign wide = (width_code == `CCW_PFW_8BIT);

	// upper two bits only exist in the 8-bit layout
	always_comb begin
		current_level   = {2'h0, status_word[`CCW_PRIO_LOW_HI:`CCW_PRIO_LOW_LO]};
		requested_level = {2'h0, cause_word[`CCW_PRIO_LOW_HI:`CCW_PRIO_LOW_LO]};
		if (wide) begin
			current_level[7]   = status_word[`CCW_STAT_MSB_BIT];
			current_level[6]   = status_word[`CCW_STAT_MSB2_BIT];
			requested_level[7] = cause_word[`CCW_CAUSE_MSB_BIT];
			requested_level[6] = cause_word[`CCW_CAUSE_MSB2_BIT];
		end
	end
endmodule

`default_nettype wire

/* hw/ccw_capability_word.sv */
// ccw_capability_word.sv: third capability word of the system-control coprocessor.
// assumes the core's coprocessor move path on clk_sys and a boot strap pin.
`default_nettype none

`include "ccw_cfg.svh"

module ccw_capability_word
	import ccw_pkg::*;
#(
	parameter bit       BOTH_SETS     = 1'b1,
	parameter bit       CMP_ONLY      = 1'b0,
	parameter bit       MCU_EXT       = 1'b1,
	parameter bit       TLR_PRESENT   = 1'b1,
	parameter bit       INH_PRESENT   = 1'b0,
	parameter bit       SX2_PRESENT   = 1'b1,
	parameter bit       SX_PRESENT    = 1'b1,
	parameter bit [2:0] CMP_REVISION  = `CCW_CIR_REV1
) (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        cp0_rd_en,
	input  wire logic        cp0_wr_en,
	input  wire logic [4:0]  cp0_reg_num,
	input  wire logic [2:0]  cp0_reg_sel,
	input  wire logic [31:0] cp0_wr_data,
	input  wire logic        boot_set_select,
	input  wire logic [31:0] status_word,
	input  wire logic [31:0] cause_word,
	output logic [31:0]      cp0_rd_data,
	output logic             cp0_rd_valid,
	output logic             cp0_wr_ack,
	output logic             wr_ignored,
	output logic             cap_ready,
	output logic [1:0]       priority_field_width,
	output ccw_iss_t         instruction_set_support,
	output logic             exception_entry_set_select,
	output ccw_prio_t        current_priority_level,
	output ccw_prio_t        requested_priority_level
);

	// ****************************************
	// functions
	// ****************************************

	// one decode serves both the read and the write path
	function automatic logic sel_hit(input logic [4:0] num, input logic [2:0] sel);
		sel_hit = (num == `CCW_REG_NUM) && (sel == `CCW_REG_SEL);
	endfunction

	// set-support code from the boot strap and build options
	function automatic ccw_iss_t iss_code(input logic strap);
		if (BOTH_SETS) begin
			iss_code = strap ? `CCW_ISS_BOTH_CMP : `CCW_ISS_BOTH_BASE;
		end else if (CMP_ONLY) begin
			iss_code = `CCW_ISS_CMP_ONLY;
		end else begin
			iss_code = `CCW_ISS_BASE_ONLY;
		end
	endfunction

	// the full word; unlisted bits stay zero
	function automatic logic [31:0] build_word(
		input ccw_iss_t iss,
		input logic     ees
	);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[`CCW_NEXT_BIT]              = 1'b1;
		w[`CCW_PFW_HI:`CCW_PFW_LO]    = `CCW_PFW_8BIT;
		w[`CCW_CIR_HI:`CCW_CIR_LO]    = CMP_REVISION;
		w[`CCW_MCU_BIT]               = MCU_EXT;
		w[`CCW_EES_BIT]               = ees;
		w[`CCW_ISS_HI:`CCW_ISS_LO]    = iss;
		w[`CCW_TLR_BIT]               = TLR_PRESENT;
		w[`CCW_INH_BIT]               = INH_PRESENT;
		w[`CCW_SX2_BIT]               = SX2_PRESENT;
		w[`CCW_SX_BIT]                = SX_PRESENT;
		w[`CCW_EVC_BIT]               = 1'b1;
		w[`CCW_VIS_BIT]               = 1'b1;
		build_word = w;
	endfunction

	// ****************************************
	// strap input
	// ****************************************

	logic boot_sync;

	// the strap is a pin, so it is synchronised before use
	// a strap change after capture waits for the next reset
	ccw_sync #(
		.WIDTH    (1)
	) u_boot_sync (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.async_in (boot_set_select),
		.sync_out (boot_sync)
	);

	// ****************************************
	// capture sequence
	// ****************************************

	ccw_state_t state_q;
	ccw_state_t state_d;
	logic [1:0] settle_q;
	logic [1:0] settle_d;
	logic       settle_done;

	// two stages fill the synchroniser; the spare edge is margin
	assign settle_done = (settle_q == `CCW_SETTLE_CYC);

	// wait for the synchroniser to fill before sampling the strap
	always_comb begin
		state_d  = state_q;
		settle_d = settle_q;
		case (state_q)
			CCW_ST_SETTLE: begin
				if (settle_done) begin
					state_d = CCW_ST_CAPTURE;
				end else begin
					settle_d = settle_q + 2'h1;
				end
			end
			CCW_ST_CAPTURE: begin
				state_d = CCW_ST_RUN;
			end
			CCW_ST_RUN: begin
				state_d = CCW_ST_RUN;
			end
			default: begin
				state_d  = CCW_ST_SETTLE;
				settle_d = 2'h0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			state_q  <= CCW_ST_SETTLE;
			settle_q <= 2'h0;
		end else begin
			state_q  <= state_d;
			settle_q <= settle_d;
		end
	end

	assign cap_ready = (state_q == CCW_ST_RUN);

	// ****************************************
	// strap-derived fields
	// ****************************************

	ccw_iss_t iss_q;
	ccw_iss_t iss_d;
	logic     ees_q;
	logic     ees_d;
	logic     capture;
	logic     wr_hit;

	assign capture = (state_q == CCW_ST_CAPTURE);
	assign wr_hit  = cp0_wr_en && sel_hit(cp0_reg_num, cp0_reg_sel);

	// set support is strap-only: no write path reaches it
	always_comb begin
		iss_d = iss_q;
		if (capture) begin
			iss_d = iss_code(boot_sync);
		end
	end

	// reset value is a constant; the strap lands during capture
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			iss_q <= `CCW_ISS_BASE_ONLY;
		end else begin
			iss_q <= iss_d;
		end
	end

	// entry select is the only bit a write may change
	always_comb begin
		ees_d = ees_q;
		if (capture) begin
			ees_d = boot_sync;
		end else if (wr_hit && cap_ready) begin
			ees_d = cp0_wr_data[`CCW_EES_BIT];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			ees_q <= 1'b0;
		end else begin
			ees_q <= ees_d;
		end
	end

	// the core uses this for base-offset vectors only
	assign exception_entry_set_select = ees_q;
	assign instruction_set_support    = iss_q;
	assign priority_field_width       = `CCW_PFW_8BIT;

	// ****************************************
	// move read answer
	// ****************************************

	logic [31:0] rd_data_q;
	logic [31:0] rd_data_d;
	logic        rd_valid_q;
	logic        rd_valid_d;
	logic        rd_hit;
	logic [31:0] word_now;

	assign word_now = build_word(iss_q, ees_q);
	assign rd_hit   = cp0_rd_en && sel_hit(cp0_reg_num, cp0_reg_sel);

	// unselected reads answer zero but still complete
	// reads before capture show the reset fields, not the strap
	always_comb begin
		rd_valid_d = cp0_rd_en;
		rd_data_d  = 32'h0000_0000;
		if (rd_hit) begin
			rd_data_d = word_now;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rd_data_q  <= 32'h0000_0000;
			rd_valid_q <= 1'b0;
		end else begin
			rd_data_q  <= rd_data_d;
			rd_valid_q <= rd_valid_d;
		end
	end

	assign cp0_rd_data  = rd_data_q;
	assign cp0_rd_valid = rd_valid_q;

	// ****************************************
	// move write answer
	// ****************************************

	logic        wr_ack_q;
	logic        wr_ack_d;
	logic        wr_ign_q;
	logic        wr_ign_d;
	logic [31:0] ro_mask;
	logic        ro_clash;

	// every bit except the entry select is read-only
	assign ro_mask  = ~(32'h0000_0001 << `CCW_EES_BIT);
	assign ro_clash = |((cp0_wr_data ^ word_now) & ro_mask);

	// advisory once ready: a clashing write still moves the entry select
	always_comb begin
		wr_ack_d = cp0_wr_en;
		wr_ign_d = 1'b0;
		if (wr_hit) begin
			wr_ign_d = ro_clash || !cap_ready;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			wr_ack_q <= 1'b0;
			wr_ign_q <= 1'b0;
		end else begin
			wr_ack_q <= wr_ack_d;
			wr_ign_q <= wr_ign_d;
		end
	end

	assign cp0_wr_ack = wr_ack_q;
	assign wr_ignored = wr_ign_q;

	// ****************************************
	// priority levels
	// ****************************************

	ccw_prio_t cur_lvl;
	ccw_prio_t req_lvl;
	ccw_prio_t cur_q;
	ccw_prio_t req_q;
	ccw_prio_t cur_d;
	ccw_prio_t req_d;

	// extraction follows the fixed width code
	ccw_prio_map u_prio_map (
		.status_word     (status_word),
		.cause_word      (cause_word),
		.width_code      (priority_field_width),
		.current_level   (cur_lvl),
		.requested_level (req_lvl)
	);

	// levels follow the core words every cycle
	always_comb begin
		cur_d = cur_lvl;
		req_d = req_lvl;
	end

	// registered so the data outputs come from flops
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cur_q <= 8'h00;
			req_q <= 8'h00;
		end else begin
			cur_q <= cur_d;
			req_q <= req_d;
		end
	end

	assign current_priority_level   = cur_q;
	assign requested_priority_level = req_q;

endmodule

`default_nettype wire

/* verif/ccw_capability_word_sva.sv */
// ccw_capability_word_sva.sv: port checks for the capability word block.
// assumes ccw_pkg is compiled first; bound to every design instance.
`default_nettype none

module ccw_capability_word_sva
	import ccw_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic        cp0_rd_en,
	input wire logic        cp0_wr_en,
	input wire logic [4:0]  cp0_reg_num,
	input wire logic [2:0]  cp0_reg_sel,
	input wire logic [31:0] cp0_wr_data,
	input wire logic        boot_set_select,
	input wire logic [31:0] status_word,
	input wire logic [31:0] cause_word,
	input wire logic [31:0] cp0_rd_data,
	input wire logic        cp0_rd_valid,
	input wire logic        cp0_wr_ack,
	input wire logic        wr_ignored,
	input wire logic        cap_ready,
	input wire logic [1:0]  priority_field_width,
	input wire ccw_iss_t    instruction_set_support,
	input wire logic        exception_entry_set_select,
	input wire ccw_prio_t   current_priority_level,
	input wire ccw_prio_t   requested_priority_level
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// ****************************************
	// selected moves
	// ****************************************
	// reads only once captured: the strap may land on the same edge
	sequence s_rd;
		cap_ready && cp0_rd_en && !cp0_wr_en && cp0_reg_num == 5'h10 && cp0_reg_sel == 3'h3;
	endsequence
	sequence s_wr;
		cp0_wr_en && !cp0_rd_en && cp0_reg_num == 5'h10 && cp0_reg_sel == 3'h3;
	endsequence

	a_top_bits: assert property (s_rd |=> cp0_rd_data[31:23] == 9'h100)
		else $error("top bits wrong");
	a_width_rev: assert property (s_rd |=> cp0_rd_data[22:18] == 5'h08)
		else $error("width or revision wrong");
	a_vector_bits: assert property (s_rd |=> cp0_rd_data[6:5] == 2'h3)
		else $error("vector bits wrong");
	a_entry_bit: assert property (s_rd |=> cp0_rd_data[16] == exception_entry_set_select)
		else $error("entry bit differs");
	a_set_field: assert property (s_rd |=> cp0_rd_data[15:14] == instruction_set_support)
		else $error("set field differs");
	a_write_entry: assert property (s_wr ##0 cap_ready |=>
		cp0_wr_ack && exception_entry_set_select == $past(cp0_wr_data[16]))
		else $error("entry write lost");
	a_early_write: assert property (s_wr ##0 !cap_ready |=> wr_ignored && cp0_wr_ack)
		else $error("early write not refused");
	a_iss_frozen: assert property (cap_ready && $past(cap_ready) |->
		$stable(instruction_set_support))
		else $error("set field moved");
	a_current_level: assert property (1'b1 |=> current_priority_level ==
		{$past(status_word[18]), $past(status_word[16]), $past(status_word[15:10])})
		else $error("current level wrong");
	a_request_level: assert property (1'b1 |=> requested_priority_level ==
		{$past(cause_word[17]), $past(cause_word[16]), $past(cause_word[15:10])})
		else $error("requested level wrong");
	a_read_answer: assert property (cp0_rd_en |=> cp0_rd_valid)
		else $error("read not answered");
endmodule

bind ccw_capability_word ccw_capability_word_sva u_sva (
	.clk_sys(clk_sys), .reset(reset), .cp0_rd_en(cp0_rd_en), .cp0_wr_en(cp0_wr_en),
	.cp0_reg_num(cp0_reg_num), .cp0_reg_sel(cp0_reg_sel), .cp0_wr_data(cp0_wr_data),
	.boot_set_select(boot_set_select), .status_word(status_word), .cause_word(cause_word),
	.cp0_rd_data(cp0_rd_data), .cp0_rd_valid(cp0_rd_valid), .cp0_wr_ack(cp0_wr_ack),
	.wr_ignored(wr_ignored), .cap_ready(cap_ready),
	.priority_field_width(priority_field_width),
	.instruction_set_support(instruction_set_support),
	.exception_entry_set_select(exception_entry_set_select),
	.current_priority_level(current_priority_level),
	.requested_priority_level(requested_priority_level)
);

`default_nettype wire

/* verif/ccw_core_model.sv */
// ccw_core_model.sv: core side of the coprocessor move path.
// assumes a free running clk_sys; the bench calls access().
`default_nettype none

module ccw_core_model (
	input  wire logic        clk_sys,
	input  wire logic [31:0] cp0_rd_data,
	input  wire logic        cp0_rd_valid,
	input  wire logic        cp0_wr_ack,
	input  wire logic        wr_ignored,
	output var logic         cp0_rd_en,
	output var logic         cp0_wr_en,
	output var logic [4:0]   cp0_reg_num,
	output var logic [2:0]   cp0_reg_sel,
	output var logic [31:0]  cp0_wr_data
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		cp0_rd_en = 1'b0;
		cp0_wr_en = 1'b0;
		cp0_reg_num = 5'h0;
		cp0_reg_sel = 3'h0;
		cp0_wr_data = 32'h0;
	end

	// ****************************************
	// one move, taken at the rising edge between two falling edges
	// ****************************************
	task automatic access(input logic wr, input logic [2:0] sel, input logic [31:0] wd,
			output logic [31:0] rd, output logic [2:0] flags);
		@(negedge clk_sys);
		cp0_rd_en = !wr;
		cp0_wr_en = wr;
		cp0_reg_num = 5'h10;
		cp0_reg_sel = sel;
		cp0_wr_data = wd;
		@(negedge clk_sys);
		rd = cp0_rd_data;
		flags = {cp0_rd_valid, cp0_wr_ack, wr_ignored};
		cp0_rd_en = 1'b0;
		cp0_wr_en = 1'b0;
		// idle lines change so a stale address cannot pass for a request
		cp0_reg_num = 5'h0F;
		cp0_reg_sel = ~sel;
		cp0_wr_data = ~wd;
	endtask
endmodule

`default_nettype wire

/* verif/ccw_capability_word_tb.sv */
// ccw_capability_word_tb.sv: self-checking bench for the capability word.
// assumes design, package, core model and checker are compiled before it.
`default_nettype none

module ccw_capability_word_tb
	import ccw_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys;
	logic        reset;
	logic        boot_set_select;
	logic [31:0] status_word;
	logic [31:0] cause_word;
	logic        cp0_rd_en;
	logic        cp0_wr_en;
	logic [4:0]  cp0_reg_num;
	logic [2:0]  cp0_reg_sel;
	logic [31:0] cp0_wr_data;
	logic [31:0] cp0_rd_data;
	logic        cp0_rd_valid;
	logic        cp0_wr_ack;
	logic        wr_ignored;
	logic        cap_ready;
	logic [1:0]  pfw;
	ccw_iss_t    iss;
	logic        ees;
	ccw_prio_t   cur_lvl;
	ccw_prio_t   req_lvl;
	int          err_total = 0;
	int          checked = 0;
	logic [31:0] d;
	logic [2:0]  f;

	ccw_capability_word dut (
		.clk_sys(clk_sys), .reset(reset), .cp0_rd_en(cp0_rd_en), .cp0_wr_en(cp0_wr_en),
		.cp0_reg_num(cp0_reg_num), .cp0_reg_sel(cp0_reg_sel), .cp0_wr_data(cp0_wr_data),
		.boot_set_select(boot_set_select), .status_word(status_word),
		.cause_word(cause_word), .cp0_rd_data(cp0_rd_data), .cp0_rd_valid(cp0_rd_valid),
		.cp0_wr_ack(cp0_wr_ack), .wr_ignored(wr_ignored), .cap_ready(cap_ready),
		.priority_field_width(pfw), .instruction_set_support(iss),
		.exception_entry_set_select(ees), .current_priority_level(cur_lvl),
		.requested_priority_level(req_lvl)
	);

	ccw_core_model u_core (
		.clk_sys(clk_sys), .cp0_rd_data(cp0_rd_data), .cp0_rd_valid(cp0_rd_valid),
		.cp0_wr_ack(cp0_wr_ack), .wr_ignored(wr_ignored), .cp0_rd_en(cp0_rd_en),
		.cp0_wr_en(cp0_wr_en), .cp0_reg_num(cp0_reg_num), .cp0_reg_sel(cp0_reg_sel),
		.cp0_wr_data(cp0_wr_data)
	);

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic final_report;
		if (err_total == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic do_reset(input logic strap);
		@(negedge clk_sys);
		reset = 1'b1;
		boot_set_select = strap;
		repeat (12) @(negedge clk_sys);
		chk("ready in reset", 32'h0, {31'h0, cap_ready});
		reset = 1'b0;
	endtask

	task automatic wait_ready;
		for (int i = 0; i < 10 && cap_ready !== 1'b1; i++) begin
			@(negedge clk_sys);
		end
		chk("ready", 32'h1, {31'h0, cap_ready});
	endtask

	task automatic rd(input logic [2:0] sel);
		u_core.access(1'b0, sel, 32'h0, d, f);
		chk("read flags", 32'h4, {29'h0, f});
	endtask

	// levels lag the core words by one edge
	task automatic prio(input logic [31:0] s, input logic [31:0] c, input ccw_prio_t ec,
			input ccw_prio_t er);
		@(negedge clk_sys);
		status_word = s;
		cause_word = c;
		@(negedge clk_sys);
		chk("current level", {24'h0, ec}, {24'h0, cur_lvl});
		chk("requested level", {24'h0, er}, {24'h0, req_lvl});
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial begin
		reset = 1'b1;
		boot_set_select = 1'b1;
		status_word = 32'h0;
		cause_word = 32'h0;
		do_reset(1'b1);
		wait_ready;
		rd(3'h3);
		chk("word strap high", 32'h8023EC60, d);
		chk("width code", 32'h1, {30'h0, pfw});
		chk("set support", 32'h3, {30'h0, iss});
		chk("entry select", 32'h1, {31'h0, ees});
		rd(3'h2);
		chk("other select", 32'h0, d);
		u_core.access(1'b1, 3'h3, 32'h8022EC60, d, f);
		chk("clear flags", 32'h2, {29'h0, f});
		rd(3'h3);
		chk("word entry low", 32'h8022EC60, d);
		u_core.access(1'b1, 3'h3, 32'hFFFFFFFF, d, f);
		chk("ones flags", 32'h3, {29'h0, f});
		rd(3'h3);
		chk("word after ones", 32'h8023EC60, d);
		prio(32'h0004A800, 32'h00015400, 8'hAA, 8'h55);
		prio(32'hFFFB57FF, 32'hFFFEABFF, 8'h55, 8'hAA);
		do_reset(1'b0);
		u_core.access(1'b1, 3'h3, 32'h8023EC60, d, f);
		chk("early flags", 32'h3, {29'h0, f});
		wait_ready;
		rd(3'h3);
		chk("word strap low", 32'h8022AC60, d);
		final_report;
	end

	// whole run is under 200 cycles
	initial begin
		repeat (2000) @(posedge clk_sys);
		err_total++;
		final_report;
	end
endmodule

`default_nettype wire
